// ===== rtl/flsq_core.sv
`timescale 1ns/1ps
`default_nettype none
module flsq_core #(
   parameter int unsigned SECTOR_ERASE_CYC = flsq_pkg::SECTOR_ERASE_TIME_US * flsq_pkg::CLK_MHZ,
   parameter int unsigned BLOCK_ERASE_CYC = flsq_pkg::BLOCK_ERASE_TIME_US * flsq_pkg::CLK_MHZ,
   parameter int unsigned CHIP_ERASE_CYC = flsq_pkg::CHIP_ERASE_TIME_US * flsq_pkg::CLK_MHZ,
   parameter int MEM_ADDR_BITS = 16,
   // Identifier value is arbitrary
   parameter logic [7:0] DEVICE_ID = 8'h3c
) (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic si_in,
   output logic so_out,
   output logic so_oe_out,
   input wire logic [2:0] protect_bits_in,
   input wire logic other_busy_in,
   output logic write_in_progress_flag_out,
   output logic write_enable_latch_out,
   output logic deep_sleep_out,
   output logic erase_start_out,
   output logic [1:0] erase_kind_out,
   output logic [23:0] erase_addr_out,
   output logic erase_done_out,
   output logic cmd_refused_out
);
   // ****************************************
   // Parameter checks
   // ****************************************
   if (MEM_ADDR_BITS < flsq_pkg::BLOCK64_LOG2 || MEM_ADDR_BITS > 24)
      $error("MEM_ADDR_BITS out of range");
   if (SECTOR_ERASE_CYC < 1 || BLOCK_ERASE_CYC < 1 || CHIP_ERASE_CYC < 1)
      $error("Erase cycle counts must be at least one");

   localparam logic [24:0] MEM_SIZE = 25'h1 << MEM_ADDR_BITS;
   localparam logic [23:0] MEM_MASK = 24'(MEM_SIZE - 25'h1);

   typedef struct packed {
      flsq_pkg::flsq_state_t st;
      logic cs_prev;
      logic [31:0] timer;
      logic write_enable_latch;
      flsq_pkg::flsq_kind_t kind;
      logic [23:0] base;
      logic start;
      logic done;
      logic refused;
   } flsq_core_t;
   flsq_core_t core_reg;
   flsq_core_t core_next;

   logic cs_sync;
   logic cs_rise;
   logic [7:0] op;
   logic [23:0] addr;
   logic [5:0] cnt;
   logic [8:0] status;
   logic addr_erase;
   logic chip_erase;
   flsq_pkg::flsq_kind_t addr_kind;

   // ****************************************
   // Link side and select crossing
   // ****************************************
   assign status = {core_reg.st == flsq_pkg::ST_ASLEEP, 3'h0, protect_bits_in,
      core_reg.write_enable_latch, write_in_progress_flag_out};

   flsq_link #(
      .DEVICE_ID(DEVICE_ID)
   ) u_link (
      .sclk_in(sclk_in),
      .arst_n_in(arst_n_in),
      .cs_n_in(cs_n_in),
      .si_in(si_in),
      .status_in(status),
      .so_out(so_out),
      .so_oe_out(so_oe_out),
      .opcode_out(op),
      .addr_out(addr),
      .bit_cnt_out(cnt)
   );

   flsq_sync #(
      .WIDTH(1),
      .RESET_VAL(1'b1)
   ) u_cs_sync (
      .clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .d_in(cs_n_in),
      .q_out(cs_sync)
   );

   // Link words are frozen once select is high, so reading them here is safe
   assign cs_rise = cs_sync & ~core_reg.cs_prev;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic int kind_log2(input flsq_pkg::flsq_kind_t k);
      int r;
      r = flsq_pkg::SECTOR_LOG2;
      if (k == flsq_pkg::EK_BLOCK32)
         r = flsq_pkg::BLOCK32_LOG2;
      else if (k == flsq_pkg::EK_BLOCK64)
         r = flsq_pkg::BLOCK64_LOG2;
      return r;
   endfunction

   function automatic logic [31:0] kind_cycles(input flsq_pkg::flsq_kind_t k);
      logic [31:0] r;
      r = 32'(SECTOR_ERASE_CYC);
      if (k == flsq_pkg::EK_BLOCK32 || k == flsq_pkg::EK_BLOCK64)
         r = 32'(BLOCK_ERASE_CYC);
      else if (k == flsq_pkg::EK_CHIP)
         r = 32'(CHIP_ERASE_CYC);
      return r;
   endfunction

   function automatic logic [23:0] align_base(input logic [23:0] a, input int l2);
      logic [24:0] span;
      span = (25'h1 << l2) - 25'h1;
      return a & ~span[23:0] & MEM_MASK;
   endfunction

   // Protected span is the top of memory, halving per step below all-ones
   function automatic logic prot_hit(input logic [2:0] bp, input logic [23:0] base, input int l2);
      logic [24:0] lo;
      logic [24:0] hi;
      lo = MEM_SIZE - (MEM_SIZE >> (3'h7 - bp));
      hi = {1'b0, base} + (25'h1 << l2) - 25'h1;
      return (bp == flsq_pkg::BP_ALL) || ((bp != flsq_pkg::BP_NONE) && (hi >= lo));
   endfunction

   always_comb
   begin
      addr_kind = flsq_pkg::EK_SECTOR;
      if (op == flsq_pkg::OP_BLOCK32_ERASE)
         addr_kind = flsq_pkg::EK_BLOCK32;
      else if (op == flsq_pkg::OP_BLOCK64_ERASE)
         addr_kind = flsq_pkg::EK_BLOCK64;
   end
   assign addr_erase = (op == flsq_pkg::OP_SECTOR_ERASE) || (op == flsq_pkg::OP_BLOCK32_ERASE)
      || (op == flsq_pkg::OP_BLOCK64_ERASE);
   assign chip_erase = (op == flsq_pkg::OP_CHIP_ERASE_A) || (op == flsq_pkg::OP_CHIP_ERASE_B);

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb
   begin
      core_next = core_reg;
      core_next.cs_prev = cs_sync;
      core_next.start = 1'b0;
      core_next.done = 1'b0;
      core_next.refused = 1'b0;
      case (core_reg.st)
         flsq_pkg::ST_ERASE:
         begin
            if (core_reg.timer == 32'h0)
            begin
               core_next.st = flsq_pkg::ST_IDLE;
               core_next.done = 1'b1;
            end
            else
               core_next.timer = core_reg.timer - 32'h1;
         end
         flsq_pkg::ST_SLEEP_WAIT:
         begin
            if (core_reg.timer == 32'h0)
               core_next.st = flsq_pkg::ST_ASLEEP;
            else
               core_next.timer = core_reg.timer - 32'h1;
         end
         flsq_pkg::ST_WAKE:
         begin
            if (core_reg.timer == 32'h0)
               core_next.st = flsq_pkg::ST_IDLE;
            else
               core_next.timer = core_reg.timer - 32'h1;
         end
         default:
         begin
         end
      endcase
      if (cs_rise)
      begin
         if (core_reg.st == flsq_pkg::ST_ASLEEP)
         begin
            if (op == flsq_pkg::OP_WAKE_ID && cnt >= flsq_pkg::CNT_OPCODE)
            begin
               core_next.st = flsq_pkg::ST_WAKE;
               core_next.timer = 32'(flsq_pkg::RELEASE_CYC - 1);
            end
            else
               core_next.refused = 1'b1;
         end
         else if (core_reg.st != flsq_pkg::ST_IDLE || other_busy_in)
         begin
            // Running cycle, sleep entry or wake recovery: drop everything
            if (op == flsq_pkg::OP_DEEP_SLEEP || op == flsq_pkg::OP_WAKE_ID || addr_erase
               || chip_erase)
               core_next.refused = 1'b1;
         end
         else if (op == flsq_pkg::OP_WRITE_EN && cnt == flsq_pkg::CNT_OPCODE)
            core_next.write_enable_latch = 1'b1;
         else if (op == flsq_pkg::OP_WRITE_DIS && cnt == flsq_pkg::CNT_OPCODE)
            core_next.write_enable_latch = 1'b0;
         else if (addr_erase)
         begin
            if (cnt == flsq_pkg::CNT_ADDR && core_reg.write_enable_latch
               && !prot_hit(protect_bits_in, align_base(addr, kind_log2(addr_kind)),
               kind_log2(addr_kind)))
            begin
               core_next.st = flsq_pkg::ST_ERASE;
               core_next.kind = addr_kind;
               core_next.base = align_base(addr, kind_log2(addr_kind));
               core_next.timer = kind_cycles(addr_kind) - 32'h1;
               core_next.write_enable_latch = 1'b0;
               core_next.start = 1'b1;
            end
            else
               core_next.refused = 1'b1;
         end
         else if (chip_erase)
         begin
            if (cnt == flsq_pkg::CNT_OPCODE && core_reg.write_enable_latch
               && (protect_bits_in == flsq_pkg::BP_NONE || protect_bits_in == flsq_pkg::BP_ALL))
            begin
               core_next.st = flsq_pkg::ST_ERASE;
               core_next.kind = flsq_pkg::EK_CHIP;
               core_next.base = 24'h0;
               core_next.timer = kind_cycles(flsq_pkg::EK_CHIP) - 32'h1;
               core_next.write_enable_latch = 1'b0;
               core_next.start = 1'b1;
            end
            else
               core_next.refused = 1'b1;
         end
         else if (op == flsq_pkg::OP_DEEP_SLEEP)
         begin
            if (cnt == flsq_pkg::CNT_OPCODE)
            begin
               core_next.st = flsq_pkg::ST_SLEEP_WAIT;
               core_next.timer = 32'(flsq_pkg::SLEEP_ENTRY_CYC - 1);
            end
            else
               core_next.refused = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         core_reg <= '0;
         core_reg.st <= flsq_pkg::ST_IDLE;
         core_reg.cs_prev <= 1'b1;
      end
      else
         core_reg <= core_next;
   end

   assign write_in_progress_flag_out = (core_reg.st == flsq_pkg::ST_ERASE) || other_busy_in;
   assign write_enable_latch_out = core_reg.write_enable_latch;
   assign deep_sleep_out = core_reg.st == flsq_pkg::ST_ASLEEP;
   assign erase_start_out = core_reg.start;
   assign erase_kind_out = core_reg.kind;
   assign erase_addr_out = core_reg.base;
   assign erase_done_out = core_reg.done;
   assign cmd_refused_out = core_reg.refused;

   // ****************************************
   // Checks
   // ****************************************
   logic [31:0] erase_len_reg;
   logic [31:0] sleep_len_reg;
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         erase_len_reg <= 32'h0;
         sleep_len_reg <= 32'h0;
      end
      else
      begin
         erase_len_reg <= (core_reg.st == flsq_pkg::ST_ERASE) ? erase_len_reg + 32'h1 : 32'h0;
         sleep_len_reg <= (core_reg.st == flsq_pkg::ST_SLEEP_WAIT) ? sleep_len_reg + 32'h1 : 32'h0;
      end
   end

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   sequence s_frame_end;
      cs_rise;
   endsequence
   sequence s_sleep_req_busy;
      s_frame_end ##0 write_in_progress_flag_out
         ##0 (core_reg.st inside {flsq_pkg::ST_ERASE, flsq_pkg::ST_IDLE})
         ##0 (op == flsq_pkg::OP_DEEP_SLEEP);
   endsequence

   a_erase_sets_wip: assert property (erase_start_out |-> write_in_progress_flag_out
      ##1 write_in_progress_flag_out) else $error("Busy flag not set by erase");
   a_erase_length: assert property (erase_done_out
      |-> erase_len_reg == kind_cycles(core_reg.kind))
      else $error("Erase cycle length wrong");
   a_wel_cleared: assert property ($rose(core_reg.st == flsq_pkg::ST_ERASE) |-> !core_reg.write_enable_latch
      throughout (core_reg.st == flsq_pkg::ST_ERASE)[*1]) else $error("Latch set during erase");
   a_bad_count: assert property (s_frame_end ##0 addr_erase ##0 (cnt != flsq_pkg::CNT_ADDR)
      |=> !erase_start_out) else $error("Misframed erase started");
   a_chip_protect: assert property (erase_start_out && erase_kind_out == flsq_pkg::EK_CHIP
      |-> $past(protect_bits_in) == flsq_pkg::BP_NONE || $past(protect_bits_in) == flsq_pkg::BP_ALL)
      else $error("Chip erase under partial protection");
   a_sleep_delay: assert property ($rose(deep_sleep_out) |-> $past(sleep_len_reg)
      == 32'(flsq_pkg::SLEEP_ENTRY_CYC - 1)) else $error("Sleep entry delay wrong");
   a_sleep_holds: assert property (s_frame_end ##0 deep_sleep_out ##0 (op != flsq_pkg::OP_WAKE_ID)
      |=> deep_sleep_out [*2]) else $error("Sleep left on other opcode");
   a_busy_drop: assert property (s_sleep_req_busy |=> core_reg.st != flsq_pkg::ST_SLEEP_WAIT
      ##1 !deep_sleep_out) else $error("Sleep taken during erase");
   a_wake_blocks: assert property (core_reg.st == flsq_pkg::ST_WAKE |=> !erase_start_out)
      else $error("Command taken during wake recovery");
   a_wake_busy: assert property (s_frame_end ##0 write_in_progress_flag_out
      ##0 (core_reg.st inside {flsq_pkg::ST_ERASE, flsq_pkg::ST_IDLE})
      ##0 (op == flsq_pkg::OP_WAKE_ID) |=> cmd_refused_out
      && (core_reg.st == $past(core_reg.st) || erase_done_out))
      else $error("Wake disturbed busy cycle");
endmodule
`default_nettype wire

// ===== rtl/flsq_link.sv
`timescale 1ns/1ps
`default_nettype none
module flsq_link #(
   parameter logic [7:0] DEVICE_ID = 8'h3c
) (
   input wire logic sclk_in,
   input wire logic arst_n_in,
   input wire logic cs_n_in,
   input wire logic si_in,
   input wire logic [8:0] status_in,
   output logic so_out,
   output logic so_oe_out,
   output logic [7:0] opcode_out,
   output logic [23:0] addr_out,
   output logic [5:0] bit_cnt_out
);
   typedef struct packed {
      logic [5:0] cnt;
      logic [7:0] opcode;
      logic [31:0] sh;
      logic [8:0] st_s1;
      logic [8:0] st_s2;
   } flsq_link_t;
   flsq_link_t link_reg;
   flsq_link_t link_next;
   logic new_frame_reg;
   logic so_reg;
   logic oe_reg;
   logic [2:0] bit_idx;
   logic id_ok;
   logic stat_ok;
   // ****************************************
   // Frame start marker, set while deselected
   // ****************************************
   always_ff @(posedge sclk_in or negedge arst_n_in or posedge cs_n_in)
   begin
      if (!arst_n_in)
         new_frame_reg <= 1'b1;
      else if (cs_n_in)
         new_frame_reg <= 1'b1;
      else
         new_frame_reg <= 1'b0;
   end
   // ****************************************
   // Input shifter on rising edges
   // ****************************************
   always_comb
   begin
      link_next = link_reg;
      link_next.st_s1 = status_in;
      link_next.st_s2 = link_reg.st_s1;
      if (!cs_n_in)
      begin
         if (new_frame_reg)
         begin
            link_next.cnt = 6'h01;
            link_next.sh = {31'h0, si_in};
         end
         else
         begin
            link_next.sh = {link_reg.sh[30:0], si_in};
            // Wrap within the last byte so the identifier keeps repeating
            if (link_reg.cnt == flsq_pkg::CNT_MAX)
               link_next.cnt = flsq_pkg::CNT_MAX - (flsq_pkg::CNT_OPCODE - 6'h01);
            else
               link_next.cnt = link_reg.cnt + 6'h01;
            if (link_reg.cnt == flsq_pkg::CNT_OPCODE - 6'h01)
               link_next.opcode = {link_reg.sh[6:0], si_in};
         end
      end
   end
   always_ff @(posedge sclk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         link_reg <= '0;
      else
         link_reg <= link_next;
   end
   // ****************************************
   // Output shifter on falling edges
   // ****************************************
   assign bit_idx = 3'h7 - link_reg.cnt[2:0];
   assign id_ok = (link_reg.opcode == flsq_pkg::OP_WAKE_ID) && (link_reg.cnt >= flsq_pkg::CNT_ADDR)
      && !link_reg.st_s2[flsq_pkg::STAT_WIP_BIT];
   assign stat_ok = (link_reg.opcode == flsq_pkg::OP_READ_STATUS)
      && (link_reg.cnt >= flsq_pkg::CNT_OPCODE) && !link_reg.st_s2[flsq_pkg::STAT_SLEEP_BIT];
   always_ff @(negedge sclk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         so_reg <= 1'b0;
         oe_reg <= 1'b0;
      end
      else if (new_frame_reg)
      begin
         so_reg <= 1'b0;
         oe_reg <= 1'b0;
      end
      else
      begin
         oe_reg <= id_ok || stat_ok;
         if (id_ok)
            so_reg <= DEVICE_ID[bit_idx];
         else
            so_reg <= link_reg.st_s2[bit_idx];
      end
   end
   assign so_out = so_reg;
   assign so_oe_out = oe_reg & ~cs_n_in;
   assign opcode_out = link_reg.opcode;
   assign addr_out = link_reg.sh[23:0];
   assign bit_cnt_out = link_reg.cnt;
endmodule
`default_nettype wire

// ===== rtl/flsq_pkg.sv
`default_nettype none
package flsq_pkg;
   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int CLK_MHZ = 25;
   localparam int CLK_PERIOD_NS = 40;
   localparam int SECTOR_ERASE_TIME_US = 50000;
   localparam int BLOCK_ERASE_TIME_US = 200000;
   localparam int CHIP_ERASE_TIME_US = 1000000;
   localparam int SLEEP_ENTRY_DELAY_NS = 3000;
   localparam int RELEASE_TIME_NS = 3000;
   localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RELEASE_CYC = (RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ****************************************
   // Opcodes and frame lengths
   // ****************************************
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
   localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
   localparam logic [7:0] OP_WAKE_ID = 8'hab;
   localparam logic [7:0] OP_WRITE_EN = 8'h06;
   localparam logic [7:0] OP_WRITE_DIS = 8'h04;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [5:0] CNT_OPCODE = 6'h08;
   localparam logic [5:0] CNT_ADDR = 6'h20;
   localparam logic [5:0] CNT_MAX = 6'h3f;
   // ****************************************
   // Geometry, protection, status layout
   // ****************************************
   localparam int SECTOR_LOG2 = 12;
   localparam int BLOCK32_LOG2 = 15;
   localparam int BLOCK64_LOG2 = 16;
   localparam logic [2:0] BP_NONE = 3'h0;
   localparam logic [2:0] BP_ALL = 3'h7;
   localparam int STAT_WIP_BIT = 0;
   localparam int STAT_WEL_BIT = 1;
   localparam int STAT_BP_LSB = 2;
   localparam int STAT_SLEEP_BIT = 8;
   typedef enum logic [1:0] {EK_SECTOR = 2'h0, EK_BLOCK32 = 2'h1, EK_BLOCK64 = 2'h2,
      EK_CHIP = 2'h3} flsq_kind_t;
   typedef enum logic [4:0] {ST_IDLE = 5'h01, ST_ERASE = 5'h02, ST_SLEEP_WAIT = 5'h04,
      ST_ASLEEP = 5'h08, ST_WAKE = 5'h10} flsq_state_t;
endpackage
`default_nettype wire

// ===== rtl/flsq_sync.sv
`timescale 1ns/1ps
`default_nettype none
module flsq_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } flsq_sync_t;
   flsq_sync_t sync_reg;
   flsq_sync_t sync_next;
   // ****************************************
   // Two-stage synchroniser
   // ****************************************
   always_comb
   begin
      sync_next.s1 = d_in;
      sync_next.s2 = sync_reg.s1;
   end
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         sync_reg <= {RESET_VAL, RESET_VAL};
      else
         sync_reg <= sync_next;
   end
   assign q_out = sync_reg.s2;
endmodule
`default_nettype wire

// ===== tb/flsq_host.sv
`timescale 1ns/1ps
`default_nettype none
module flsq_host (
   output logic sclk_out,
   output logic cs_n_out,
   output logic si_out,
   input wire logic so_in
);
   // ****************************************
   // Idle lines
   // ****************************************
   initial
   begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      si_out = 1'b1;
   end
   // ****************************************
   // Frame driver, clock only within frames
   // ****************************************
   task automatic xfer(input logic [39:0] b, input int n, input int nrd, output logic [15:0] rx);
      rx = 16'h0;
      cs_n_out = 1'b0;
      #7;
      for (int i = 0; i < n + nrd; i++)
      begin
         if (i < n) si_out = b[39 - i];
         else si_out = ~si_out;
         #16;
         sclk_out = 1'b1;
         if (i >= n) rx = {rx[14:0], so_in};
         #16;
         sclk_out = 1'b0;
      end
      #7;
      cs_n_out = 1'b1;
      si_out = ~si_out;
   endtask
endmodule
`default_nettype wire

// ===== tb/serial_flash_erase_powerdown_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_erase_powerdown_tb;
   localparam logic [7:0] ID = 8'h5a; // Arbitrary identifier value
   logic ref_clk_in, arst_n_in, sclk, cs_n, si, so, so_oe, write_in_progress_flag, write_enable_latch, sleep, st, done, rf, busy;
   logic [2:0] bp;
   logic [1:0] kind;
   logic [23:0] eaddr;
   logic [15:0] rx;
   int failures, samples_checked, seed;
   initial
   begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   flsq_core #(.SECTOR_ERASE_CYC(30), .BLOCK_ERASE_CYC(40), .CHIP_ERASE_CYC(50),
      .MEM_ADDR_BITS(16), .DEVICE_ID(ID)) flsq_core_inst (.ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in), .sclk_in(sclk), .cs_n_in(cs_n), .si_in(si), .so_out(so),
      .so_oe_out(so_oe), .protect_bits_in(bp), .other_busy_in(busy),
      .write_in_progress_flag_out(write_in_progress_flag), .write_enable_latch_out(write_enable_latch), .deep_sleep_out(sleep),
      .erase_start_out(st), .erase_kind_out(kind), .erase_addr_out(eaddr),
      .erase_done_out(done), .cmd_refused_out(rf));
   flsq_host flsq_host_inst (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si),
      .so_in(so_oe ? so : ~so));
   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [23:0] base(input logic [1:0] k, input logic [23:0] a);
      case (k)
         2'h0: return a & 24'hfff000;
         2'h1: return a & 24'hff8000;
         2'h2: return a & 24'hff0000;
         default: return 24'h0;
      endcase
   endfunction
   task automatic drive(input logic [2:0] p, input logic b);
      @(posedge ref_clk_in);
      bp <= p;
      busy <= b;
   endtask
   // Frame, then watch 8 core cycles for start or refusal
   task automatic cmd(input logic [39:0] b, input int n, input int nrd, output logic [1:0] res);
      res = 2'h0;
      flsq_host_inst.xfer(b, n, nrd, rx);
      repeat (8)
      begin
         @(posedge ref_clk_in);
         #1;
         if (st === 1'b1) res[1] = 1'b1;
         if (rf === 1'b1) res[0] = 1'b1;
      end
   endtask
   task automatic erase(input logic [7:0] op, input logic [1:0] k, input int n,
      input logic [1:0] exp);
      logic [23:0] a;
      logic [1:0] r;
      int cnt;
      a = 24'($random(seed)) & 24'h00ffff;
      // Partial protection covers the top sector
      if (bp != 3'h0)
         a = (exp == 2'h2) ? (a & 24'h00efff) : (a | 24'h00f000);
      cmd({8'h06, 32'h0}, 8, 0, r);
      cmd({op, a, 8'h00}, n, 0, r);
      chk("erase result", 32'(exp), 32'(r));
      if (exp == 2'h2)
      begin
         chk("erase kind", 32'(k), 32'(kind));
         chk("erase base", 32'(base(k, a)), 32'(eaddr));
         chk("wip busy", 1, 32'(write_in_progress_flag));
         chk("wel cleared", 0, 32'(write_enable_latch));
         cmd({8'h05, 32'h0}, 8, 8, r);
         chk("status wip", 1, 32'(rx[0]));
         cnt = 0;
         while (write_in_progress_flag !== 1'b0 && cnt < 200)
         begin
            @(posedge ref_clk_in);
            #1;
            cnt++;
         end
         chk("wip cleared", 0, 32'(write_in_progress_flag));
         chk("erase done", 1, 32'(done));
      end
   endtask
   task automatic finish_test;
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      logic [1:0] r;
      seed = 32'ha0ee2658;
      arst_n_in = 1'b0;
      bp = 3'h0;
      busy = 1'b0;
      repeat (6) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      #1;
      chk("reset state", 0, 32'({write_in_progress_flag, write_enable_latch, sleep}));
      erase(8'h20, 2'h0, 32, 2'h2);
      erase(8'h52, 2'h1, 32, 2'h2);
      erase(8'hd8, 2'h2, 32, 2'h2);
      erase(8'h60, 2'h3, 8, 2'h2);
      erase(8'hc7, 2'h3, 8, 2'h2);
      erase(8'h20, 2'h0, 31, 2'h1);
      erase(8'hd8, 2'h2, 33, 2'h1);
      erase(8'h60, 2'h3, 9, 2'h1);
      drive(3'h7, 1'b0);
      erase(8'h52, 2'h1, 32, 2'h1);
      erase(8'hc7, 2'h3, 8, 2'h2);
      drive(3'h3, 1'b0);
      erase(8'h60, 2'h3, 8, 2'h1);
      erase(8'h20, 2'h0, 32, 2'h1);
      erase(8'h20, 2'h0, 32, 2'h2);
      drive(3'h0, 1'b0);
      cmd({8'h04, 32'h0}, 8, 0, r);
      cmd({8'h20, 32'h0}, 32, 0, r);
      chk("erase without latch", 1, 32'(r));
      drive(3'h0, 1'b1);
      cmd({8'hb9, 32'h0}, 8, 0, r);
      chk("sleep while busy", 1, 32'(r));
      cmd({8'hab, 32'h0}, 32, 16, r);
      chk("id while busy", 1, 32'(r));
      drive(3'h0, 1'b0);
      cmd({8'hb9, 32'h0}, 9, 0, r);
      chk("sleep long frame", 1, 32'(r));
      cmd({8'hb9, 32'h0}, 8, 0, r);
      chk("sleep delayed", 0, 32'({r, sleep}));
      repeat (80) @(posedge ref_clk_in);
      #1;
      chk("asleep", 1, 32'(sleep));
      cmd({8'h06, 32'h0}, 8, 0, r);
      chk("cmd in sleep", 32'h2, 32'({r, write_enable_latch}));
      cmd({8'hab, 32'h0}, 8, 0, r);
      cmd({8'h06, 32'h0}, 8, 0, r);
      chk("cmd in recovery", 32'h0, 32'({r, write_enable_latch}));
      repeat (80) @(posedge ref_clk_in);
      #1;
      chk("awake", 0, 32'(sleep));
      cmd({8'h06, 32'h0}, 8, 0, r);
      chk("cmd after recovery", 1, 32'(write_enable_latch));
      cmd({8'hab, 32'h0}, 32, 16, r);
      chk("identifier", 32'({ID, ID}), 32'(rx));
      cmd({8'hb9, 32'h0}, 8, 0, r);
      repeat (80) @(posedge ref_clk_in);
      #1;
      chk("asleep before reset", 1, 32'(sleep));
      @(posedge ref_clk_in);
      arst_n_in <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      #1;
      chk("standby after reset", 0, 32'({sleep, write_enable_latch}));
      finish_test;
   end
   initial
   begin
      #(40 * 40000);
      failures++;
      $display("[ERR] watchdog expected completion seen timeout");
      finish_test;
   end
endmodule
`default_nettype wire
